// file: rtl/l1ss_ltr_pkg.sv
// Constants for the L1 substates and latency tolerance register bank
// Assumes 32-bit configuration dwords addressed by 12-bit byte offsets
package l1ss_ltr_pkg;

    // Bus shape
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int BE_W   = 4;
    localparam int WORD_LSB = 2;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFF_LATENCY  = 12'h234;
    localparam logic [ADDR_W-1:0] OFF_CAP_HDR  = 12'h240;
    localparam logic [ADDR_W-1:0] OFF_CAP      = 12'h244;
    localparam logic [ADDR_W-1:0] OFF_CTRL_ONE = 12'h248;
    localparam logic [ADDR_W-1:0] OFF_CTRL_TWO = 12'h24c;

    // Latency dword fields
    localparam int SNOOP_VAL_LSB     = 0;
    localparam int SNOOP_SCALE_LSB   = 10;
    localparam int NOSNOOP_VAL_LSB   = 16;
    localparam int NOSNOOP_SCALE_LSB = 26;
    localparam int LAT_VAL_W         = 10;
    localparam int LAT_SCALE_W       = 3;
    localparam logic [LAT_VAL_W-1:0]   LAT_VAL_RESET   = 10'h000;
    localparam logic [LAT_SCALE_W-1:0] LAT_SCALE_RESET = 3'h0;

    // Capability header fields
    localparam int CAP_ID_LSB  = 0;
    localparam int CAP_ID_W    = 16;
    localparam int CAP_VER_LSB = 16;
    localparam int CAP_VER_W   = 4;
    localparam int NEXT_LSB    = 20;
    localparam int NEXT_W      = 12;
    localparam logic [CAP_ID_W-1:0]  CAP_ID      = 16'h001e;
    localparam logic [CAP_VER_W-1:0] CAP_VER     = 4'h1;
    localparam logic [NEXT_W-1:0]    NEXT_UP     = 12'h260;
    localparam logic [NEXT_W-1:0]    NEXT_DOWN   = 12'h250;

    // Capability and control bits
    localparam int PCIPM_L11_BIT = 1;
    localparam int ASPM_L11_BIT  = 3;
    localparam int L1SS_BIT      = 4;
    localparam logic PCIPM_L11_SUP_RESET = 1'b1;
    localparam logic ASPM_L11_SUP_RESET  = 1'b0;
    localparam logic L1SS_SUP_RESET      = 1'b1;
    localparam logic CTRL_EN_RESET       = 1'b0;
    localparam logic [DATA_W-1:0] CTRL_TWO_VALUE = 32'h0000_0000;

    // Access sequencer
    typedef enum logic [1:0] {
        ACC_IDLE   = 2'b01,
        ACC_ANSWER = 2'b10
    } access_state_t;

endpackage

// file: rtl/rw_field.sv
// Read-write field of a configuration dword with byte-lane writes
// Assumes the write strobe is a single-cycle pulse on mclk
`timescale 1ns/10ps

module rw_field #(
    parameter int            W     = 1,
    parameter int            LSB   = 0,
    parameter logic [W-1:0]  RESET = '0
) (
    // Clock and reset
    input  wire logic                            mclk,
    input  wire logic                            resetn,
    // Write side
    input  wire logic                            wr_en,
    input  wire logic [l1ss_ltr_pkg::BE_W-1:0]   wr_be,
    input  wire logic [l1ss_ltr_pkg::DATA_W-1:0] wr_data,
    // Field value
    output logic      [W-1:0]                    value
);

    typedef struct packed {
        logic [W-1:0] value;
    } field_state_t;

    field_state_t s_q;
    field_state_t s_d;
    logic [W-1:0] wmask;

    ////////////////////////////////////////////////////////////////////////
    // Byte lane of each bit
    generate
        for (genvar i = 0; i < W; i++) begin : g_mask
            assign wmask[i] = wr_be[(LSB + i) / 8];
        end
    endgenerate

    always_comb begin
        s_d = s_q;
        if (wr_en) begin
            s_d.value = (s_q.value & ~wmask) | (wr_data[LSB +: W] & wmask);
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '{value: RESET};
        end else begin
            s_q <= s_d;
        end
    end

    assign value = s_q.value;

endmodule // rw_field

// file: rtl/cap_override.sv
// Read-only capability bits whose defaults the loaders may replace
// Assumes the loader presents one-cycle load requests on mclk
`timescale 1ns/10ps

module cap_override (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic resetn,
    // Loader side
    input  wire logic load_req,
    input  wire logic load_from_eeprom,
    input  wire logic load_pcipm_l11,
    input  wire logic load_aspm_l11,
    input  wire logic load_l1ss,
    // Capability bits
    output logic      pcipm_l11_sup,
    output logic      aspm_l11_sup,
    output logic      l1ss_sup
);

    typedef struct packed {
        logic pcipm;
        logic aspm;
        logic l1ss;
    } cap_state_t;

    cap_state_t s_q;
    cap_state_t s_d;

    ////////////////////////////////////////////////////////////////////////
    // Eeprom may set all three, serial loaders only the aspm bit
    always_comb begin
        s_d = s_q;
        if (load_req) begin
            s_d.aspm = load_aspm_l11;
            if (load_from_eeprom) begin
                s_d.pcipm = load_pcipm_l11;
                s_d.l1ss  = load_l1ss;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '{pcipm: l1ss_ltr_pkg::PCIPM_L11_SUP_RESET,
                     aspm:  l1ss_ltr_pkg::ASPM_L11_SUP_RESET,
                     l1ss:  l1ss_ltr_pkg::L1SS_SUP_RESET};
        end else begin
            s_q <= s_d;
        end
    end

    assign pcipm_l11_sup = s_q.pcipm;
    assign aspm_l11_sup  = s_q.aspm;
    assign l1ss_sup      = s_q.l1ss;

endmodule // cap_override

// file: rtl/pcie_l1_substates_ltr_regs.sv
// Latency tolerance upper half and L1 PM substates capability registers
// Assumes a simple configuration access port and a capability loader port
`timescale 1ns/10ps

module pcie_l1_substates_ltr_regs #(
    parameter bit IS_UPSTREAM = 1'b1
) (
    // Clock and reset
    input  wire logic                                mclk,
    input  wire logic                                resetn,
    // Configuration access
    input  wire logic                                cfg_req,
    input  wire logic                                cfg_we,
    input  wire logic [l1ss_ltr_pkg::ADDR_W-1:0]     cfg_addr,
    input  wire logic [l1ss_ltr_pkg::BE_W-1:0]       cfg_be,
    input  wire logic [l1ss_ltr_pkg::DATA_W-1:0]     cfg_wdata,
    output logic                                     cfg_ready,
    output logic                                     cfg_ack,
    output logic      [l1ss_ltr_pkg::DATA_W-1:0]     cfg_rdata,
    // Capability loader
    input  wire logic                                load_req,
    input  wire logic                                load_from_eeprom,
    input  wire logic                                load_pcipm_l11,
    input  wire logic                                load_aspm_l11,
    input  wire logic                                load_l1ss,
    // Values to the link logic
    output logic                                     pcipm_l11_en,
    output logic                                     aspm_l11_en,
    output logic      [l1ss_ltr_pkg::LAT_VAL_W-1:0]  snoop_value,
    output logic      [l1ss_ltr_pkg::LAT_SCALE_W-1:0] snoop_scale,
    output logic      [l1ss_ltr_pkg::LAT_VAL_W-1:0]  nosnoop_value,
    output logic      [l1ss_ltr_pkg::LAT_SCALE_W-1:0] nosnoop_scale
);

    localparam int DW = l1ss_ltr_pkg::DATA_W;
    localparam int WL = l1ss_ltr_pkg::WORD_LSB;
    localparam int AW = l1ss_ltr_pkg::ADDR_W;
    localparam logic [l1ss_ltr_pkg::NEXT_W-1:0] NEXT_PTR =
        IS_UPSTREAM ? l1ss_ltr_pkg::NEXT_UP : l1ss_ltr_pkg::NEXT_DOWN;

    typedef struct packed {
        l1ss_ltr_pkg::access_state_t state;
        logic [DW-1:0]               rdata;
    } main_state_t;

    main_state_t s_q;
    main_state_t s_d;

    logic          take;
    logic          hit_lat;
    logic          hit_hdr;
    logic          hit_cap;
    logic          hit_ctl1;
    logic          hit_ctl2;
    logic          wr_lat;
    logic          wr_ctl1;
    logic          pcipm_sup;
    logic          aspm_sup;
    logic          l1ss_sup;
    logic [DW-1:0] rd_word;

    ////////////////////////////////////////////////////////////////////////
    // Decode
    assign take     = cfg_req && (s_q.state == l1ss_ltr_pkg::ACC_IDLE);
    assign hit_lat  = IS_UPSTREAM &&
        (cfg_addr[AW-1:WL] == l1ss_ltr_pkg::OFF_LATENCY[AW-1:WL]);
    assign hit_hdr  =
        (cfg_addr[AW-1:WL] == l1ss_ltr_pkg::OFF_CAP_HDR[AW-1:WL]);
    assign hit_cap  =
        (cfg_addr[AW-1:WL] == l1ss_ltr_pkg::OFF_CAP[AW-1:WL]);
    assign hit_ctl1 =
        (cfg_addr[AW-1:WL] == l1ss_ltr_pkg::OFF_CTRL_ONE[AW-1:WL]);
    assign hit_ctl2 =
        (cfg_addr[AW-1:WL] == l1ss_ltr_pkg::OFF_CTRL_TWO[AW-1:WL]);
    assign wr_lat   = take && cfg_we && hit_lat;
    assign wr_ctl1  = take && cfg_we && hit_ctl1;

    ////////////////////////////////////////////////////////////////////////
    // Latency fields
    rw_field #(
        .W     (l1ss_ltr_pkg::LAT_VAL_W),
        .LSB   (l1ss_ltr_pkg::SNOOP_VAL_LSB),
        .RESET (l1ss_ltr_pkg::LAT_VAL_RESET)
    ) u_snoop_val (
        .mclk    (mclk),
        .resetn  (resetn),
        .wr_en   (wr_lat),
        .wr_be   (cfg_be),
        .wr_data (cfg_wdata),
        .value   (snoop_value)
    );

    rw_field #(
        .W     (l1ss_ltr_pkg::LAT_SCALE_W),
        .LSB   (l1ss_ltr_pkg::SNOOP_SCALE_LSB),
        .RESET (l1ss_ltr_pkg::LAT_SCALE_RESET)
    ) u_snoop_scale (
        .mclk    (mclk),
        .resetn  (resetn),
        .wr_en   (wr_lat),
        .wr_be   (cfg_be),
        .wr_data (cfg_wdata),
        .value   (snoop_scale)
    );

    rw_field #(
        .W     (l1ss_ltr_pkg::LAT_VAL_W),
        .LSB   (l1ss_ltr_pkg::NOSNOOP_VAL_LSB),
        .RESET (l1ss_ltr_pkg::LAT_VAL_RESET)
    ) u_nosnoop_val (
        .mclk    (mclk),
        .resetn  (resetn),
        .wr_en   (wr_lat),
        .wr_be   (cfg_be),
        .wr_data (cfg_wdata),
        .value   (nosnoop_value)
    );

    rw_field #(
        .W     (l1ss_ltr_pkg::LAT_SCALE_W),
        .LSB   (l1ss_ltr_pkg::NOSNOOP_SCALE_LSB),
        .RESET (l1ss_ltr_pkg::LAT_SCALE_RESET)
    ) u_nosnoop_scale (
        .mclk    (mclk),
        .resetn  (resetn),
        .wr_en   (wr_lat),
        .wr_be   (cfg_be),
        .wr_data (cfg_wdata),
        .value   (nosnoop_scale)
    );

    ////////////////////////////////////////////////////////////////////////
    // Control one enables
    rw_field #(
        .W     (1),
        .LSB   (l1ss_ltr_pkg::PCIPM_L11_BIT),
        .RESET (l1ss_ltr_pkg::CTRL_EN_RESET)
    ) u_pcipm_en (
        .mclk    (mclk),
        .resetn  (resetn),
        .wr_en   (wr_ctl1),
        .wr_be   (cfg_be),
        .wr_data (cfg_wdata),
        .value   (pcipm_l11_en)
    );

    rw_field #(
        .W     (1),
        .LSB   (l1ss_ltr_pkg::ASPM_L11_BIT),
        .RESET (l1ss_ltr_pkg::CTRL_EN_RESET)
    ) u_aspm_en (
        .mclk    (mclk),
        .resetn  (resetn),
        .wr_en   (wr_ctl1),
        .wr_be   (cfg_be),
        .wr_data (cfg_wdata),
        .value   (aspm_l11_en)
    );

    ////////////////////////////////////////////////////////////////////////
    // Loadable capability bits
    cap_override u_cap (
        .mclk             (mclk),
        .resetn           (resetn),
        .load_req         (load_req),
        .load_from_eeprom (load_from_eeprom),
        .load_pcipm_l11   (load_pcipm_l11),
        .load_aspm_l11    (load_aspm_l11),
        .load_l1ss        (load_l1ss),
        .pcipm_l11_sup    (pcipm_sup),
        .aspm_l11_sup     (aspm_sup),
        .l1ss_sup         (l1ss_sup)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read mux, reserved and unmapped bits read zero
    always_comb begin
        rd_word = '0;
        if (hit_lat) begin
            rd_word[l1ss_ltr_pkg::SNOOP_VAL_LSB +: l1ss_ltr_pkg::LAT_VAL_W] =
                snoop_value;
            rd_word[l1ss_ltr_pkg::SNOOP_SCALE_LSB +:
                    l1ss_ltr_pkg::LAT_SCALE_W] = snoop_scale;
            rd_word[l1ss_ltr_pkg::NOSNOOP_VAL_LSB +:
                    l1ss_ltr_pkg::LAT_VAL_W] = nosnoop_value;
            rd_word[l1ss_ltr_pkg::NOSNOOP_SCALE_LSB +:
                    l1ss_ltr_pkg::LAT_SCALE_W] = nosnoop_scale;
        end else if (hit_hdr) begin
            rd_word[l1ss_ltr_pkg::CAP_ID_LSB +: l1ss_ltr_pkg::CAP_ID_W] =
                l1ss_ltr_pkg::CAP_ID;
            rd_word[l1ss_ltr_pkg::CAP_VER_LSB +: l1ss_ltr_pkg::CAP_VER_W] =
                l1ss_ltr_pkg::CAP_VER;
            rd_word[l1ss_ltr_pkg::NEXT_LSB +: l1ss_ltr_pkg::NEXT_W] =
                NEXT_PTR;
        end else if (hit_cap) begin
            rd_word[l1ss_ltr_pkg::PCIPM_L11_BIT] = pcipm_sup;
            rd_word[l1ss_ltr_pkg::ASPM_L11_BIT]  = aspm_sup;
            rd_word[l1ss_ltr_pkg::L1SS_BIT]      = l1ss_sup;
        end else if (hit_ctl1) begin
            rd_word[l1ss_ltr_pkg::PCIPM_L11_BIT] = pcipm_l11_en;
            rd_word[l1ss_ltr_pkg::ASPM_L11_BIT]  = aspm_l11_en;
        end else if (hit_ctl2) begin
            rd_word = l1ss_ltr_pkg::CTRL_TWO_VALUE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Access sequencer
    always_comb begin
        s_d = s_q;
        case (s_q.state)
            l1ss_ltr_pkg::ACC_IDLE: begin
                if (take) begin
                    s_d.state = l1ss_ltr_pkg::ACC_ANSWER;
                    s_d.rdata = cfg_we ? '0 : rd_word;
                end
            end
            l1ss_ltr_pkg::ACC_ANSWER: begin
                s_d.state = l1ss_ltr_pkg::ACC_IDLE;
            end
            default: begin
                s_d.state = l1ss_ltr_pkg::ACC_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '{state: l1ss_ltr_pkg::ACC_IDLE, rdata: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign cfg_ready = (s_q.state == l1ss_ltr_pkg::ACC_IDLE);
    assign cfg_ack   = (s_q.state == l1ss_ltr_pkg::ACC_ANSWER);
    assign cfg_rdata = s_q.rdata;

endmodule // pcie_l1_substates_ltr_regs

// file: bench/l1ss_regs_monitor.sv
// Concurrent checks on the latency and L1 substates register bank
// Assumes it is bound to the bank and sees only its ports
`timescale 1ns/10ps

module l1ss_regs_monitor #(
    parameter bit IS_UPSTREAM = 1'b1
) (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        resetn,
    // Configuration access
    input wire logic        cfg_req,
    input wire logic        cfg_we,
    input wire logic [11:0] cfg_addr,
    input wire logic [3:0]  cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic        cfg_ready,
    input wire logic        cfg_ack,
    input wire logic [31:0] cfg_rdata,
    // Link values
    input wire logic        pcipm_l11_en,
    input wire logic        aspm_l11_en,
    input wire logic [9:0]  snoop_value,
    input wire logic [9:0]  nosnoop_value,
    input wire logic [2:0]  nosnoop_scale
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    logic       take;
    logic [9:0] w;
    assign take = cfg_req && cfg_ready;
    assign w    = cfg_addr[11:2];

    ////////////////////////////////////////////////////////////////////////
    a_ack_one_cycle: assert property (take |=> cfg_ack ##1 !cfg_ack)
        else $error("ack not a single pulse");
    a_nosnoop_value: assert property (
        take && cfg_we && w == 10'h08d && cfg_be[2] && IS_UPSTREAM
        |=> nosnoop_value[7:0] == $past(cfg_wdata[23:16]))
        else $error("no-snoop value not written");
    a_nosnoop_scale: assert property (
        take && cfg_we && w == 10'h08d && cfg_be[3] && IS_UPSTREAM
        |=> nosnoop_scale == $past(cfg_wdata[28:26]))
        else $error("no-snoop scale not written");
    a_snoop_value: assert property (
        take && cfg_we && w == 10'h08d && cfg_be[0] && IS_UPSTREAM
        |=> snoop_value[7:0] == $past(cfg_wdata[7:0]))
        else $error("snoop value not written");
    a_down_no_latency: assert property (
        !IS_UPSTREAM
        |-> nosnoop_value == 10'h0 && nosnoop_scale == 3'h0)
        else $error("downstream latency field not zero");
    a_hdr_id: assert property (
        take && !cfg_we && w == 10'h090
        |=> cfg_rdata[15:0] == 16'h001e)
        else $error("header identifier wrong");
    a_hdr_next: assert property (
        take && !cfg_we && w == 10'h090
        |=> cfg_rdata[31:16] == (IS_UPSTREAM ? 16'h2601 : 16'h2501))
        else $error("header version or pointer wrong");
    a_cap_reserved: assert property (
        take && !cfg_we && w == 10'h091
        |=> cfg_rdata[31:5] == 27'h0 && !cfg_rdata[2] && !cfg_rdata[0])
        else $error("capability reserved bits set");
    a_ctrl_write: assert property (
        take && cfg_we && w == 10'h092 && cfg_be[0]
        |=> pcipm_l11_en == $past(cfg_wdata[1])
        && aspm_l11_en == $past(cfg_wdata[3]))
        else $error("control one enables not written");
    a_ctrl_hold: assert property (
        !(take && cfg_we && w == 10'h092)
        |=> $stable({pcipm_l11_en, aspm_l11_en}))
        else $error("control one enables changed");
    a_ctrl_two_zero: assert property (
        take && !cfg_we && w == 10'h093
        |=> cfg_rdata == 32'h0)
        else $error("control two not zero");
endmodule // l1ss_regs_monitor

bind pcie_l1_substates_ltr_regs l1ss_regs_monitor #(
    .IS_UPSTREAM(IS_UPSTREAM)
) i_l1ss_regs_monitor (
    .mclk(mclk), .resetn(resetn), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_ready(cfg_ready), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .pcipm_l11_en(pcipm_l11_en), .aspm_l11_en(aspm_l11_en),
    .snoop_value(snoop_value), .nosnoop_value(nosnoop_value),
    .nosnoop_scale(nosnoop_scale)
);

// file: bench/pcie_l1_substates_ltr_regs_test.sv
// Self-checking bench for the latency and L1 substates register bank
// Assumes an upstream and a downstream instance, each with the monitor bound beside it
`timescale 1ns/10ps

module pcie_l1_substates_ltr_regs_test;
    logic        mclk = 1'b0, resetn = 1'b0, cfg_req = 1'b0, cfg_we = 1'b0;
    logic        load_req = 1'b0, load_from_eeprom = 1'b0;
    logic        load_pcipm_l11 = 1'b0, load_aspm_l11 = 1'b0, load_l1ss = 1'b0;
    logic [11:0] cfg_addr = 12'h0, a;
    logic [3:0]  cfg_be = 4'h0, be;
    logic [31:0] cfg_wdata = 32'h0, cfg_rdata, rd, lat, ctrl, cap, d, m;
    logic        cfg_ready, cfg_ack, pcipm_l11_en, aspm_l11_en;
    logic        dn_ready, dn_ack, dn_pen, dn_aen;
    logic [9:0]  snoop_value, nosnoop_value, dn_sv, dn_nv;
    logic [2:0]  snoop_scale, nosnoop_scale, dn_ss, dn_ns;
    logic [31:0] dn_rdata, rd_dn;
    int          err_count = 0, num_checks = 0, cyc = 0;
    integer      seed = 32'h00c7e991;
    logic [11:0] addrs [6] = '{12'h234, 12'h240, 12'h244, 12'h248, 12'h24c,
                               12'h238};

    pcie_l1_substates_ltr_regs #(
        .IS_UPSTREAM(1'b1)
    ) i_pcie_l1_substates_ltr_regs (
        .mclk(mclk), .resetn(resetn), .cfg_req(cfg_req), .cfg_we(cfg_we),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_ready(cfg_ready), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
        .load_req(load_req), .load_from_eeprom(load_from_eeprom),
        .load_pcipm_l11(load_pcipm_l11), .load_aspm_l11(load_aspm_l11),
        .load_l1ss(load_l1ss), .pcipm_l11_en(pcipm_l11_en),
        .aspm_l11_en(aspm_l11_en), .snoop_value(snoop_value),
        .snoop_scale(snoop_scale), .nosnoop_value(nosnoop_value),
        .nosnoop_scale(nosnoop_scale));

    // Downstream port sharing the same stimulus
    pcie_l1_substates_ltr_regs #(
        .IS_UPSTREAM(1'b0)
    ) i_pcie_l1_substates_ltr_regs_dn (
        .mclk(mclk), .resetn(resetn), .cfg_req(cfg_req), .cfg_we(cfg_we),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_ready(dn_ready), .cfg_ack(dn_ack), .cfg_rdata(dn_rdata),
        .load_req(load_req), .load_from_eeprom(load_from_eeprom),
        .load_pcipm_l11(load_pcipm_l11), .load_aspm_l11(load_aspm_l11),
        .load_l1ss(load_l1ss), .pcipm_l11_en(dn_pen),
        .aspm_l11_en(dn_aen), .snoop_value(dn_sv), .snoop_scale(dn_ss),
        .nosnoop_value(dn_nv), .nosnoop_scale(dn_ns));

    always #50 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            close_out;
        end
    end

    function automatic logic [31:0] exp_rd(input logic [11:0] x,
                                           input logic        up);
        case (x[11:2])
            10'h08d: exp_rd = up ? lat : 32'h0;
            10'h090: exp_rd = up ? 32'h2601_001e : 32'h2501_001e;
            10'h091: exp_rd = cap;
            10'h092: exp_rd = ctrl;
            default: exp_rd = 32'h0;
        endcase
    endfunction

    task automatic chk_out;
        chk({6'h0, nosnoop_scale, nosnoop_value, snoop_scale, snoop_value},
            {6'h0, lat[28:16], lat[12:0]});
        chk({30'h0, pcipm_l11_en, aspm_l11_en},
            {30'h0, ctrl[1], ctrl[3]});
        chk({6'h0, dn_ns, dn_nv, dn_ss, dn_sv}, 32'h0);
        chk({30'h0, dn_pen, dn_aen},
            {30'h0, ctrl[1], ctrl[3]});
    endtask

    task automatic access(input logic we, input logic [11:0] x,
                          input logic [3:0] b, input logic [31:0] v);
        @(negedge mclk);
        {cfg_req, cfg_we, cfg_addr, cfg_be, cfg_wdata} = {1'b1, we, x, b, v};
        @(negedge mclk);
        cfg_req = 1'b0;
        chk({28'h0, cfg_ready, cfg_ack, dn_ready, dn_ack}, 32'h5);
        rd = cfg_rdata;
        rd_dn = dn_rdata;
        @(posedge mclk);
    endtask

    task automatic do_reset;
        @(negedge mclk);
        resetn = 1'b0;
        repeat (20) @(negedge mclk);
        {lat, ctrl, cap} = {32'h0, 32'h0, 32'h12};
        chk({28'h0, cfg_ready, cfg_ack, dn_ready, dn_ack}, 32'ha);
        chk(cfg_rdata, 32'h0);
        chk(dn_rdata, 32'h0);
        chk_out;
        resetn = 1'b1;
    endtask

    task automatic read_all;
        foreach (addrs[i]) begin
            access(1'b0, addrs[i], 4'h0, 32'h0);
            chk(rd, exp_rd(addrs[i], 1'b1));
            chk(rd_dn, exp_rd(addrs[i], 1'b0));
        end
        $display("test reset values done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset;
        read_all;
        // Writes with read back, all-ones first at every place
        for (int i = 0; i < 60; i++) begin
            a = (i < 6) ? addrs[i] : addrs[{$random(seed)} % 6];
            be = (i < 6) ? 4'hf : 4'($random(seed));
            d = (i < 6) ? 32'hffff_ffff : $random(seed);
            access(1'b1, a, be, d);
            chk(rd, 32'h0);
            chk(rd_dn, 32'h0);
            m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
            if (a == 12'h234) begin
                lat = (lat & ~(m & 32'h1fff_1fff)) | (d & m & 32'h1fff_1fff);
            end
            if (a == 12'h248) begin
                ctrl = (ctrl & ~(m & 32'ha)) | (d & m & 32'ha);
            end
            access(1'b0, a, 4'h0, 32'h0);
            chk(rd, exp_rd(a, 1'b1));
            chk(rd_dn, exp_rd(a, 1'b0));
            chk_out;
        end
        $display("test writes done");
        // Loader pulses, eeprom and serial
        for (int i = 0; i < 16; i++) begin
            @(negedge mclk);
            load_req = 1'b1;
            {load_from_eeprom, load_pcipm_l11, load_aspm_l11, load_l1ss} =
                (i == 0) ? 4'h8 : (i == 1) ? 4'h7 : 4'($random(seed));
            @(negedge mclk);
            load_req = 1'b0;
            if (load_from_eeprom) begin
                cap = {27'h0, load_l1ss, load_aspm_l11, 1'b0,
                       load_pcipm_l11, 1'b0};
            end else begin
                cap[3] = load_aspm_l11;
            end
            access(1'b0, 12'h244, 4'h0, 32'h0);
            chk(rd, cap);
            chk(rd_dn, cap);
        end
        $display("test loader done");
        // Request during the answer cycle is ignored
        @(negedge mclk);
        {cfg_req, cfg_we, cfg_addr, cfg_be, cfg_wdata} =
            {1'b1, 1'b1, 12'h248, 4'hf, 32'h0};
        @(negedge mclk);
        cfg_wdata = 32'ha;
        @(negedge mclk);
        cfg_req = 1'b0;
        ctrl = 32'h0;
        chk({30'h0, cfg_ack, dn_ack}, 32'h0);
        chk_out;
        $display("test refused request done");
        do_reset;
        read_all;
        close_out;
    end
endmodule // pcie_l1_substates_ltr_regs_test
